// >>> hdl/stx_uart_tx.sv
// Contract
// - zero divisor stops baud generator
// - buffer to shifter sets empty flag
// - next transfer nine sixteenths into stop
// - empty flag reads one after reset
// - no frame until data written
// - enable rise loads all-ones preamble
// - zero start bit, one stop bit
// - parity replaces character msb
// - empty flag and enable raise irq
// - idle line holds logic one
// - disabling finishes current frame
// - enable toggle queues one idle character
// - send break repeats all-zero characters
// - break end followed by one high
// - break is ten or eleven zeros
// - no detect: framing error, full, zeros
// - detect: only break flag set
// - mid-character break stores partial first
// - collision check compares at sample point; select 10 compares at tick 11 instead
// - collision aborts, flags, blocks sending
// - collision flag cleared while disabled
// - char length selects eight or nine
// - bit rate is baud tick over sixteen
//
// Added by the designer: the AHB-Lite register port and the address map.
module stx_uart_tx
   import stx_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic      [31:0] o_hrdata,
   output logic             o_hreadyout,
   output logic             o_hresp,
   input  wire logic        i_rxd,
   output logic             o_txd,
   output logic             o_tx_irq
);
   // ==========================================================
   // registers and state
   logic [15:0]   baud_div;
   stx_ctrl_one_s ctrl1;
   stx_ctrl_two_s ctrl2;
   logic [8:0]    tx_buf;
   logic          tx_buffer_empty_flag;
   logic          col_flag;
   logic [3:0]    rx_flags;
   logic [8:0]    rx_data;
   logic          wr_pend;
   logic [7:0]    wr_addr;
   logic [15:0]   bcnt;
   logic          rtick;
   logic          busy;
   logic [10:0]   shreg;
   logic [3:0]    sub;
   logic [3:0]    nleft;
   stx_kind_e     kind;
   logic          pre_pend;
   logic          staged;
   logic [8:0]    stage_d;
   logic          ton_q;
   logic [3:0]    flen;
   logic          rx_line;
   logic          col_check;
   logic [3:0]    col_pt;
   logic          bound;
   logic          ev_stage;
   logic          ev_col;
   logic          ev_direct;
   logic          ld_go;
   stx_kind_e     ld_kind;
   logic [10:0]   ld_word;
   logic          tx_done;
   stx_rx_state_e rxs;
   logic [3:0]    rsub;
   logic [3:0]    ridx;
   logic [8:0]    rsh;
   logic [3:0]    zrun;
   logic [3:0]    zr_next;
   logic [8:0]    rx_char;
   logic          smp_now;
   logic          at_stop;
   logic          rx_store;
   logic          rx_brk;
   logic [3:0]    rx_set;
   logic [31:0]   rd_mux;

   // frame build: start, character, stop; parity in char msb
   function automatic logic [10:0] mk_frame(input logic [8:0] d,
                                            input stx_ctrl_one_s c);
      logic [8:0] ch;
      ch = c.char9 ? d : {1'b1, d[7:0]};
      if (c.parity_en && c.char9) begin
         ch[8] = ^ch[7:0] ^ c.parity_odd;
      end else if (c.parity_en) begin
         ch[7] = ^ch[6:0] ^ c.parity_odd;
      end
      return {1'b1, ch, 1'b0};
   endfunction

   // ==========================================================
   // ahb-lite slave, zero wait states
   assign o_hreadyout = 1'b1;
   assign o_hresp     = 1'b0;

   // latch write address phase
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else if (i_hready) begin
         wr_pend <= i_hsel && i_htrans[1] && i_hwrite && (i_hsize == 3'h2);
         wr_addr <= i_haddr[7:0];
      end
   end

   // read mux, unmapped reads as zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (i_haddr[7:0])
         STX_OFS_BAUD:   rd_mux = {16'h0000, baud_div};
         STX_OFS_CTRL1:  rd_mux = {24'h000000, ctrl1};
         STX_OFS_CTRL2:  rd_mux = {29'h0, ctrl2};
         STX_OFS_DATA:   rd_mux = {23'h0, rx_data};
         STX_OFS_STATUS: rd_mux = {25'h0, col_flag, rx_flags, tx_done, tx_buffer_empty_flag};
         default:        rd_mux = 32'h0000_0000;
      endcase
   end

   // read data registered during address phase
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_hrdata <= 32'h0000_0000;
      end else if (i_hready && i_hsel && i_htrans[1] && !i_hwrite) begin
         o_hrdata <= rd_mux;
      end
   end

   // configuration writes
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         baud_div <= STX_BAUD_RST;
         ctrl1    <= STX_CTRL1_RST;
         ctrl2    <= STX_CTRL2_RST;
      end else if (wr_pend) begin
         if (wr_addr == STX_OFS_BAUD) baud_div <= i_hwdata[15:0];
         if (wr_addr == STX_OFS_CTRL1) ctrl1 <= i_hwdata[7:0];
         if (wr_addr == STX_OFS_CTRL2) ctrl2 <= i_hwdata[2:0];
      end
   end

   // transmit buffer write
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         tx_buf <= 9'h000;
      end else if (wr_pend && wr_addr == STX_OFS_DATA) begin
         tx_buf <= i_hwdata[8:0];
      end
   end

   // ==========================================================
   // baud generator: one tick per sixteenth bit
   assign rtick = (baud_div != 16'h0000) && (bcnt >= baud_div - 16'h0001);

   always_ff @(posedge i_clk) begin
      if (i_sys_rst || baud_div == 16'h0000) begin
         bcnt <= 16'h0000;
      end else if (rtick) begin
         bcnt <= 16'h0000;
      end else begin
         bcnt <= bcnt + 16'h0001;
      end
   end

   // ==========================================================
   // transmitter control
   assign flen      = ctrl1.char9 ? STX_LEN9 : STX_LEN8;
   assign rx_line   = i_rxd ^ ctrl1.rx_invert;
   assign col_check = (ctrl1.collision_check_sel == 2'b01)
                   || (ctrl1.collision_check_sel == 2'b10);
   assign col_pt    = ctrl1.collision_check_sel[0] ? STX_COL_PT_MID : STX_COL_PT_LTE;
   // frame boundary on the last tick of the last bit, or on any tick while idle
   assign bound     = rtick && (!busy || (sub == STX_SUB_LAST && nleft == 4'h1));
   assign ev_stage  = rtick && busy && kind == K_DATA && nleft == 4'h1
                   && sub == STX_XFER_TICK - 4'h1 && !tx_buffer_empty_flag
                   && ctrl2.tx_on && !staged && !col_flag;
   assign ev_col    = col_check && rtick && busy && sub == col_pt
                   && rx_line != shreg[0];

   // choose next load at a frame boundary
   always_comb begin
      ld_go     = 1'b0;
      ld_kind   = K_DATA;
      ev_direct = 1'b0;
      if (bound && !col_flag && !ev_col) begin
         if (pre_pend) begin
            ld_go   = 1'b1;
            ld_kind = K_IDLE;
         end else if (ctrl2.tx_on && ctrl2.send_break_ctl) begin
            ld_go   = 1'b1;
            ld_kind = K_BREAK;
         end else if (busy && kind == K_BREAK) begin
            ld_go   = 1'b1;
            ld_kind = K_TAIL;
         end else if (ctrl2.tx_on && staged) begin
            ld_go = 1'b1;
         end else if (ctrl2.tx_on && !tx_buffer_empty_flag) begin
            ld_go     = 1'b1;
            ev_direct = 1'b1;
         end
      end
   end

   // shifter image for the chosen load
   always_comb begin
      case (ld_kind)
         K_IDLE:  ld_word = 11'h7FF;
         K_BREAK: ld_word = 11'h000;
         K_TAIL:  ld_word = 11'h7FF;
         default: ld_word = mk_frame(staged ? stage_d : tx_buf, ctrl1);
      endcase
   end

   // shift register, bit timing and pending work
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         busy     <= 1'b0;
         shreg    <= 11'h7FF;
         sub      <= 4'h0;
         nleft    <= 4'h0;
         kind     <= K_IDLE;
         pre_pend <= 1'b0;
         staged   <= 1'b0;
         stage_d  <= 9'h000;
         ton_q    <= 1'b0;
      end else begin
         ton_q <= ctrl2.tx_on;
         if (ctrl2.tx_on && !ton_q) begin
            pre_pend <= 1'b1;
         end else if (ld_go && ld_kind == K_IDLE) begin
            pre_pend <= 1'b0;
         end
         if (ev_stage) begin
            staged  <= 1'b1;
            stage_d <= tx_buf;
         end else if (ev_col || (ld_go && ld_kind == K_DATA)) begin
            staged <= 1'b0;
         end
         if (ev_col) begin
            busy  <= 1'b0;
            shreg <= 11'h7FF;
         end else if (ld_go) begin
            busy  <= 1'b1;
            shreg <= ld_word;
            nleft <= (ld_kind == K_TAIL) ? 4'h1 : flen;
            sub   <= 4'h0;
            kind  <= ld_kind;
         end else if (bound) begin
            busy <= 1'b0;
         end else if (rtick && busy) begin
            sub <= sub + 4'h1;
            if (sub == STX_SUB_LAST) begin
               shreg <= {1'b1, shreg[10:1]};
               nleft <= nleft - 4'h1;
            end
         end
      end
   end

   // buffer-empty flag, set wins over write clear
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         tx_buffer_empty_flag <= 1'b1;
      end else if (ev_stage || ev_direct || ev_col) begin
         tx_buffer_empty_flag <= 1'b1;
      end else if (wr_pend && wr_addr == STX_OFS_DATA) begin
         tx_buffer_empty_flag <= 1'b0;
      end
   end

   // collision flag, write one to clear
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || !col_check) begin
         col_flag <= 1'b0;
      end else if (ev_col) begin
         col_flag <= 1'b1;
      end else if (wr_pend && wr_addr == STX_OFS_STATUS && i_hwdata[STX_ST_COL]) begin
         col_flag <= 1'b0;
      end
   end

   // serial output, idle high before inversion
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_txd <= 1'b1;
      end else begin
         o_txd <= (busy ? shreg[0] : 1'b1) ^ ctrl1.tx_invert;
      end
   end

   assign tx_done  = !busy && !pre_pend && !staged && (tx_buffer_empty_flag || !ctrl2.tx_on)
                  && !(ctrl2.tx_on && ctrl2.send_break_ctl);
   assign o_tx_irq = tx_buffer_empty_flag && ctrl2.tx_empty_irq_en;

   // ==========================================================
   // receive path: framing and break detection
   assign zr_next  = zrun + 4'h1;
   assign smp_now  = rtick && rsub == STX_RX_SAMPLE && rxs != RX_IDLE;
   assign at_stop  = rxs == RX_DATA && ridx == flen - 4'h1;
   assign rx_char  = ctrl1.char9 ? rsh : {1'b0, rsh[8:1]};
   assign rx_store = smp_now && at_stop
                  && !(ctrl1.break_detect_en && !rx_line && zr_next == flen);
   assign rx_brk   = smp_now && ctrl1.break_detect_en && !rx_line
                  && zr_next == flen && (at_stop || rxs == RX_WAIT);
   assign rx_set   = {rx_brk,
                      rx_store && ctrl1.parity_en && (^rx_char ^ ctrl1.parity_odd),
                      rx_store && !rx_line,
                      rx_store};

   // receive sequencer
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         rxs  <= RX_IDLE;
         rsub <= 4'h0;
         ridx <= 4'h0;
         rsh  <= 9'h000;
         zrun <= 4'h0;
      end else if (rtick) begin
         case (rxs)
            RX_IDLE: begin
               if (!rx_line) begin
                  rxs  <= RX_DATA;
                  rsub <= 4'h0;
                  ridx <= 4'h0;
                  zrun <= 4'h0;
               end
            end
            RX_DATA: begin
               rsub <= rsub + 4'h1;
               if (rsub == STX_RX_SAMPLE) begin
                  zrun <= rx_line ? 4'h0 : zr_next;
                  ridx <= ridx + 4'h1;
                  if (ridx == 4'h0 && rx_line) begin
                     rxs <= RX_IDLE;
                  end else if (at_stop) begin
                     rxs <= rx_line ? RX_IDLE : RX_WAIT;
                  end else if (ridx != 4'h0) begin
                     rsh <= {rx_line, rsh[8:1]};
                  end
               end
            end
            RX_WAIT: begin
               rsub <= rsub + 4'h1;
               if (rsub == STX_RX_SAMPLE) begin
                  if (rx_line) begin
                     rxs <= RX_IDLE;
                  end else if (zrun != 4'hF) begin
                     zrun <= zr_next;
                  end
               end
            end
            default: rxs <= RX_IDLE;
         endcase
      end
   end

   // received character store
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         rx_data <= 9'h000;
      end else if (rx_store) begin
         rx_data <= rx_char;
      end
   end

   // receive flags, set wins over write-one clear
   for (genvar g = 0; g < STX_RX_NFLG; g++) begin : g_rxf
      always_ff @(posedge i_clk) begin
         if (i_sys_rst) begin
            rx_flags[g] <= 1'b0;
         end else if (rx_set[g]) begin
            rx_flags[g] <= 1'b1;
         end else if (wr_pend && wr_addr == STX_OFS_STATUS
                      && i_hwdata[STX_ST_RX + g]) begin
            rx_flags[g] <= 1'b0;
         end
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   property p_baud_stop;
      baud_div == 16'h0000 |=> bcnt == 16'h0000 && !busy ##0 $stable(shreg);
   endproperty
   a_baud_stop: assert property (p_baud_stop) else $error("baud runs at zero");

   property p_stage_sets;
      ev_stage |=> tx_buffer_empty_flag && staged;
   endproperty
   a_stage_sets: assert property (p_stage_sets) else $error("stage no empty");

   property p_stage_time;
      ev_stage |-> sub == 4'h8 && nleft == 4'h1 && kind == K_DATA;
   endproperty
   a_stage_time: assert property (p_stage_time) else $error("stage at wrong tick");

   property p_rst_empty;
      $past(i_sys_rst) |-> tx_buffer_empty_flag && o_txd;
   endproperty
   a_rst_empty: assert property (p_rst_empty) else $error("reset not empty");

   property p_frame_start;
      ld_go && ld_kind == K_DATA |=> shreg[0] == 1'b0 && shreg[flen - 4'h1];
   endproperty
   a_frame_start: assert property (p_frame_start) else $error("bad framing");

   property p_irq;
      o_tx_irq |-> tx_buffer_empty_flag && ctrl2.tx_empty_irq_en;
   endproperty
   a_irq: assert property (p_irq) else $error("irq without cause");

   property p_idle_high;
      !busy ##1 !$changed(ctrl1) |-> o_txd == !ctrl1.tx_invert;
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("idle not high");

   property p_col_abort;
      ev_col |=> !busy && tx_buffer_empty_flag && col_flag && !staged;
   endproperty
   a_col_abort: assert property (p_col_abort) else $error("collision no abort");

   property p_col_off;
      !col_check |=> !col_flag;
   endproperty
   a_col_off: assert property (p_col_off) else $error("collision flag held");

   property p_enable_pre;
      ctrl2.tx_on && !ton_q |=> pre_pend;
   endproperty
   a_enable_pre: assert property (p_enable_pre) else $error("no preamble");

   c_stage: cover property (ev_stage);
   c_col: cover property (ev_col);
   c_brk: cover property (rx_brk);
   c_tail: cover property (ld_go && ld_kind == K_TAIL);
endmodule

// >>> hdl/stx_pkg.sv
package stx_pkg;
   // ==========================================================
   // register byte offsets
   localparam logic [7:0] STX_OFS_BAUD   = 8'h00;
   localparam logic [7:0] STX_OFS_CTRL1  = 8'h04;
   localparam logic [7:0] STX_OFS_CTRL2  = 8'h08;
   localparam logic [7:0] STX_OFS_DATA   = 8'h0C;
   localparam logic [7:0] STX_OFS_STATUS = 8'h10;

   // ==========================================================
   // reset values
   localparam logic [15:0] STX_BAUD_RST  = 16'h0000;
   localparam logic [7:0]  STX_CTRL1_RST = 8'h00;
   localparam logic [2:0]  STX_CTRL2_RST = 3'h0;

   // ==========================================================
   // status word bit positions
   localparam int STX_ST_TX_BUFFER_EMPTY_FLAG = 0;
   localparam int STX_ST_TC   = 1;
   localparam int STX_ST_RX   = 2;
   localparam int STX_ST_COL  = 6;
   localparam int STX_RX_NFLG = 4;

   // ==========================================================
   // timing counts in baud ticks (sixteen per bit), frame lengths in bits
   localparam logic [3:0] STX_SUB_LAST   = 4'hF;
   localparam logic [3:0] STX_XFER_TICK  = 4'h9;
   localparam logic [3:0] STX_RX_SAMPLE  = 4'h7;
   localparam logic [3:0] STX_COL_PT_MID = 4'h7;
   localparam logic [3:0] STX_COL_PT_LTE = 4'hB;
   localparam logic [3:0] STX_LEN8       = 4'hA;
   localparam logic [3:0] STX_LEN9       = 4'hB;

   // ==========================================================
   // control words, field layout from msb down
   typedef struct packed {
      logic       break_detect_en;
      logic [1:0] collision_check_sel;
      logic       rx_invert;
      logic       tx_invert;
      logic       parity_odd;
      logic       parity_en;
      logic       char9;
   } stx_ctrl_one_s;

   typedef struct packed {
      logic tx_empty_irq_en;
      logic send_break_ctl;
      logic tx_on;
   } stx_ctrl_two_s;

   typedef enum logic [1:0] {K_DATA, K_IDLE, K_BREAK, K_TAIL} stx_kind_e;
   typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_WAIT} stx_rx_state_e;
endpackage

// >>> bench/stx_remote_node.sv
module stx_remote_node #(
   parameter int BIT_CLKS = 16
) (
   input  wire logic       i_clk,
   input  wire logic       i_txd,
   input  wire logic       i_echo,
   input  wire logic       i_clash,
   input  wire logic [3:0] i_low_bits,
   input  wire logic       i_low_go,
   output logic            o_rxd
);
   timeunit 1ns;
   timeprecision 1ns;
   int low_left = 0;
   // ==========================================================
   // dominant level held for a number of bit times
   always @(posedge i_clk) begin
      if (i_low_go) begin
         low_left <= int'(i_low_bits) * BIT_CLKS;
      end else if (low_left != 0) begin
         low_left <= low_left - 1;
      end
   end
   // pulled-up line: echo of the shared bus, or a forced clash
   assign o_rxd = (low_left != 0) ? 1'b0 : (i_echo ? (i_txd ^ i_clash) : 1'b1);
endmodule

// >>> bench/stx_uart_tx_tb.sv
module stx_uart_tx_tb
   import stx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, sys_rst, hsel, hwrite, rxd, txd, irq, hreadyout, hresp;
   logic        echo, clash, low_go;
   logic [31:0] haddr, hwdata, hrdata, d, fr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   int          fails, check_count, cyc, t0, t1, n;

   // ==========================================================
   // design and far-side node
   stx_uart_tx stx_uart_tx_i (.i_clk(clk), .i_sys_rst(sys_rst), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
      .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata),
      .o_hreadyout(hreadyout), .o_hresp(hresp), .i_rxd(rxd), .o_txd(txd),
      .o_tx_irq(irq));
   stx_remote_node stx_remote_node_i (.i_clk(clk), .i_txd(txd), .i_echo(echo),
      .i_clash(clash), .i_low_bits(4'hA), .i_low_go(low_go), .o_rxd(rxd));

   // ==========================================================
   // clock and cycle count
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;

   // ==========================================================
   // comparison and closing
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic give_up(input string what);
      fails++;
      $display("MISMATCH t=%0t %s timed out", $time, what);
      close_out();
   endtask

   // ==========================================================
   // bus transfers: hold each phase until hready is seen high
   task automatic wait_rdy;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) give_up("bus");
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy();
      d = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      bus(1'b1, a, v);
   endtask
   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, 32'h0);
   endtask

   // ==========================================================
   // line watching: frame start, mid-bit capture, idle check
   task automatic wait_low;
      n = 0;
      while (txd !== 1'b0 && n < 6000) begin
         @(posedge clk);
         n++;
      end
      if (txd !== 1'b0) give_up("frame");
      t0 = cyc;
   endtask
   task automatic cap(input int nbits);
      fr = 32'h0;
      wait_low();
      repeat (8) @(posedge clk);
      for (int i = 0; i < nbits; i++) begin
         fr[i] = txd;
         if (i < nbits - 1) repeat (16) @(posedge clk);
      end
   endtask
   task automatic stay_high(input int len, input string what);
      int lows;
      lows = 0;
      repeat (len) begin
         @(posedge clk);
         if (txd !== 1'b1) lows++;
      end
      chk(32'(lows), 32'h0, what);
   endtask

   // ==========================================================
   // main sequence
   initial begin
      {sys_rst, hsel, haddr, htrans, hwrite, hwdata} = {1'b1, 68'h0};
      {hsize, echo, clash, low_go, cyc} = {3'b010, 3'b000, 32'h0};
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      rd(STX_OFS_STATUS);
      chk(d & 32'h7F, 32'h03, "status after reset");
      chk(32'(irq), 32'h0, "irq after reset");
      rd(STX_OFS_BAUD);
      chk(d, 32'h0, "baud after reset");
      $display("test reset done");

      wr(STX_OFS_CTRL2, 32'h1);
      wr(STX_OFS_DATA, 32'h55);
      stay_high(300, "divisor zero");
      wr(STX_OFS_BAUD, 32'h1);
      t1 = cyc;
      cap(10);
      chk(32'(t0 - t1 >= 160 && t0 - t1 <= 166), 32'h1, "preamble");
      chk(fr, 32'({1'b1, 8'h55, 1'b0}), "frame");
      rd(STX_OFS_STATUS);
      chk(32'(d[STX_ST_TX_BUFFER_EMPTY_FLAG]), 32'h1, "empty after load");
      $display("test first frame done");

      wr(STX_OFS_CTRL2, 32'h5);
      @(posedge clk);  // enable lands at the write's last edge
      chk(32'(irq), 32'h1, "irq raised");
      wr(STX_OFS_DATA, 32'hA3);
      wait_low();
      wr(STX_OFS_DATA, 32'h3C);
      @(posedge clk);
      chk(32'(irq), 32'h0, "irq dropped");
      n = 0;
      while (irq !== 1'b1 && n < 400) begin
         @(posedge clk);
         n++;
      end
      chk(32'(cyc - t0 >= 151 && cyc - t0 <= 155), 32'h1, "stage time");
      fork
         cap(10);
         begin
            repeat (60) @(posedge clk);
            wr(STX_OFS_CTRL2, 32'h4);
         end
      join
      chk(fr, 32'({1'b1, 8'h3C, 1'b0}), "frame after disable");
      stay_high(200, "idle after disable");
      $display("test back to back done");

      wr(STX_OFS_CTRL2, 32'h1);  // re-enable only while the line is idle
      for (int k = 0; k < 2; k++) begin
         wr(STX_OFS_CTRL1, 32'(k * 4 + 2));
         wr(STX_OFS_DATA, 32'h07);
         cap(10);
         chk(fr, 32'({1'b1, ~k[0], 7'h07, 1'b0}), "parity frame");
      end
      wr(STX_OFS_CTRL1, 32'h1);
      wr(STX_OFS_DATA, 32'h1A5);
      cap(11);
      chk(fr, 32'({1'b1, 9'h1A5, 1'b0}), "nine bit frame");
      $display("test formats done");

      wr(STX_OFS_CTRL1, 32'h0);
      wr(STX_OFS_CTRL2, 32'h3);
      wait_low();
      repeat (200) @(posedge clk);
      wr(STX_OFS_CTRL2, 32'h1);
      while (txd === 1'b0 && cyc - t0 < 2000) @(posedge clk);
      chk(32'((cyc - t0) % 160), 32'h0, "break length");
      chk(32'(cyc - t0 >= 320), 32'h1, "break repeats");
      stay_high(16, "break tail");
      $display("test break send done");

      for (int k = 0; k < 2; k++) begin
         wr(STX_OFS_CTRL1, k == 0 ? 32'h80 : 32'h00);
         wr(STX_OFS_STATUS, 32'h7C);
         low_go <= 1'b1;
         @(posedge clk);
         low_go <= 1'b0;
         repeat (260) @(posedge clk);
         rd(STX_OFS_STATUS);
         chk(d & 32'h2C, k == 0 ? 32'h20 : 32'h0C, "break seen");
         rd(STX_OFS_DATA);
         chk(d & 32'h1FF, 32'h0, "data after break");
      end
      $display("test break receive done");

      wr(STX_OFS_STATUS, 32'h7C);
      echo <= 1'b1;
      for (int k = 1; k < 3; k++) begin
         clash <= 1'b0;
         wr(STX_OFS_CTRL1, 32'(k * 32));
         wr(STX_OFS_DATA, 32'h5A);
         cap(10);
         chk(fr, 32'({1'b1, 8'h5A, 1'b0}), "clean echo frame");
         rd(STX_OFS_STATUS);
         chk(32'(d[STX_ST_COL]), 32'h0, "no collision");
         clash <= 1'b1;
         wr(STX_OFS_DATA, 32'h5A);
         repeat (60) @(posedge clk);
         rd(STX_OFS_STATUS);
         chk(d & 32'h43, 32'h43, "collision flags");
         stay_high(200, "aborted frame");
         clash <= 1'b0;
         if (k == 1) wr(STX_OFS_STATUS, 32'h7C);
      end
      wr(STX_OFS_CTRL1, 32'h0);
      @(posedge clk);  // flag clears one edge after the select drops
      rd(STX_OFS_STATUS);
      chk(32'(d[STX_ST_COL]), 32'h0, "flag off when disabled");
      $display("test collision done");
      close_out();
   end
endmodule
